// File: hdl/mcu_interrupt_logic.sv
// Interrupt flags, masking, vectoring and sleep wake-up for the core.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module mcu_interrupt_logic
    import mcu_irq_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic por_reset,
    input wire logic ext_irq_pin,
    input wire logic [3:0] upper_nibble_port,
    input wire mcu_irq_pkg::core_event_type core_event,
    input wire mcu_irq_pkg::apb_req_type apb_req,
    output mcu_irq_pkg::apb_resp_type apb_resp,
    output mcu_irq_pkg::core_ctl_type core_ctl
);

    typedef struct packed {
        logic [7:0] interrupt_control;
        logic comparator_flag;
        logic comparator_irq_enable;
        logic [7:0] option;
        logic [1:0] phase;
        seq_type seq;
        logic [1:0] count;
        logic nop_due;
        logic pin_valid;
        logic ext_prev;
        logic ext_edge_seen;
        logic [3:0] port_latch;
        apb_resp_type apb;
        core_ctl_type ctl;
    } state_type;

    state_type state_reg;
    state_type state_next;

    logic [PIN_COUNT-1:0] pins;
    logic [3:0] port_now;
    logic ext_now;
    logic edge_hit;
    logic port_changed;
    logic any_enabled;
    logic irq_line;
    logic q1;
    logic flag_window;
    logic access;
    logic commit;
    logic wr_control;
    logic gie_cleared;
    logic take;
    logic [DATA_WIDTH-1:0] read_value;
    logic read_hit;

    // Byte address of a register from its index.
    function automatic logic addr_hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [7:0] index
    );
        return addr == {2'b00, index, 2'b00};
    endfunction

    // Any source whose own enable and flag are both set; the comparator also needs the peripheral enable.
    function automatic logic sources_pending(
        input logic [7:0] ctl,
        input logic cmp_flag,
        input logic cmp_en
    );
        logic t;
        logic e;
        logic p;
        logic c;
        t = ctl[TIMER_OVERFLOW_IRQ_ENABLE_BIT] &
            ctl[TIMER_OVERFLOW_FLAG_BIT]; // R11
        e = ctl[EXT_PIN_IRQ_ENABLE_BIT] & ctl[EXT_PIN_IRQ_FLAG_BIT]; // R9
        p = ctl[PORT_CHANGE_IRQ_ENABLE_BIT] &
            ctl[PORT_CHANGE_FLAG_BIT]; // R12
        c = ctl[PERIPHERAL_IRQ_ENABLE_BIT] & cmp_en & cmp_flag; // R14
        return t | e | p | c;
    endfunction

    pin_sync pin_sync_inst (
        .clock(clock),
        .reset(reset),
        .raw({upper_nibble_port, ext_irq_pin}),
        .stable(pins)
    );

    always_comb begin
        state_next = state_reg;
        state_next.ctl.vector_load = 1'b0;
        state_next.ctl.push_return = 1'b0;
        state_next.ctl.nop_insert = 1'b0;
        state_next.ctl.wake = 1'b0;
        state_next.phase = state_reg.phase + 2'h1;

        q1 = state_reg.phase == Q1_PHASE;
        flag_window = q1 || state_reg.phase == Q4_PHASE;
        ext_now = pins[0];
        port_now = pins[PIN_COUNT-1:1];

        // Nothing is compared in the first cycle after reset, but the synchroniser still holds
        // its reset zeros then, so a pin or port high at reset can pose as an edge or a port change.
        state_next.pin_valid = 1'b1;
        state_next.ext_prev = ext_now;
        if (state_reg.option[EXT_EDGE_SELECT_BIT]) begin
            edge_hit = ext_now & ~state_reg.ext_prev; // R8
        end else begin
            edge_hit = ~ext_now & state_reg.ext_prev; // R8
        end
        edge_hit = edge_hit & state_reg.pin_valid;

        // A read of the port refreshes the reference value; a change in
        // that same cycle is absorbed by the read and never flagged.
        port_changed = state_reg.pin_valid &&
            port_now != state_reg.port_latch && !core_event.port_read; // R13
        if (core_event.port_read || !state_reg.pin_valid) begin
            state_next.port_latch = port_now;
        end

        // Register bus: two-cycle access phase, effects at the last edge.
        access = apb_req.psel & apb_req.penable;
        commit = access & state_reg.apb.pready;
        state_next.apb.pready = access & ~state_reg.apb.pready;

        read_hit = 1'b1;
        read_value = READ_ZERO;
        if (addr_hit(apb_req.paddr, INTERRUPT_CONTROL_IDX)) begin
            read_value[7:0] = state_reg.interrupt_control;
        end else if (addr_hit(apb_req.paddr, PERIPHERAL_IRQ_FLAGS_IDX)) begin
            read_value[COMPARATOR_BIT] = state_reg.comparator_flag;
        end else if (addr_hit(apb_req.paddr,
                PERIPHERAL_IRQ_ENABLES_IDX)) begin
            read_value[COMPARATOR_BIT] = state_reg.comparator_irq_enable;
        end else if (addr_hit(apb_req.paddr, OPTION_IDX)) begin
            read_value[7:0] = state_reg.option;
        end else if (addr_hit(apb_req.paddr, IRQ_CORE_STATUS_IDX)) begin
            read_value[STATUS_ASLEEP_BIT] = state_reg.seq == ASLEEP;
            read_value[STATUS_PENDING_BIT] = state_reg.seq == PENDING;
            read_value[STATUS_REQUEST_BIT] = state_reg.ctl.irq_request;
            read_value[STATUS_NOP_DUE_BIT] = state_reg.nop_due;
        end else begin
            read_hit = 1'b0;
        end
        if (access && !state_reg.apb.pready) begin
            state_next.apb.prdata = apb_req.pwrite ? READ_ZERO : read_value;
            state_next.apb.pslverr = ~read_hit;
        end else begin
            state_next.apb.prdata = READ_ZERO;
            state_next.apb.pslverr = 1'b0;
        end

        wr_control = commit && apb_req.pwrite &&
            addr_hit(apb_req.paddr, INTERRUPT_CONTROL_IDX);
        gie_cleared = wr_control &&
            state_reg.interrupt_control[GLOBAL_IRQ_ENABLE_BIT] &&
            !apb_req.pwdata[GLOBAL_IRQ_ENABLE_BIT];
        if (wr_control) begin
            state_next.interrupt_control = apb_req.pwdata[7:0];
        end
        if (commit && apb_req.pwrite) begin
            if (addr_hit(apb_req.paddr, PERIPHERAL_IRQ_FLAGS_IDX)) begin
                state_next.comparator_flag = apb_req.pwdata[COMPARATOR_BIT];
            end
            if (addr_hit(apb_req.paddr, PERIPHERAL_IRQ_ENABLES_IDX)) begin
                state_next.comparator_irq_enable =
                    apb_req.pwdata[COMPARATOR_BIT];
            end
            if (addr_hit(apb_req.paddr, OPTION_IDX)) begin
                state_next.option = apb_req.pwdata[7:0];
            end
        end

        // Hardware events land after software writes, so a set that meets
        // a clear in the same cycle survives.
        state_next.ext_edge_seen = state_reg.ext_edge_seen | edge_hit;
        if (flag_window && state_next.ext_edge_seen) begin
            state_next.interrupt_control[EXT_PIN_IRQ_FLAG_BIT] = 1'b1; // R15
            state_next.ext_edge_seen = 1'b0;
        end
        if (core_event.timer_overflow) begin
            state_next.interrupt_control[TIMER_OVERFLOW_FLAG_BIT] =
                1'b1; // R11
        end
        if (port_changed) begin
            state_next.interrupt_control[PORT_CHANGE_FLAG_BIT] = 1'b1; // R12
        end
        if (core_event.comparator_change) begin
            state_next.comparator_flag = 1'b1; // R17
        end
        // Flags above ignore every enable bit. R3

        if (core_event.return_from_irq) begin
            state_next.interrupt_control[GLOBAL_IRQ_ENABLE_BIT] = 1'b1; // R5
        end

        any_enabled = sources_pending(state_reg.interrupt_control,
            state_reg.comparator_flag, state_reg.comparator_irq_enable);
        irq_line = state_reg.interrupt_control[GLOBAL_IRQ_ENABLE_BIT] &
            any_enabled; // R1 R21
        state_next.ctl.irq_request = irq_line; // R21

        // The cycle after global enable is cleared executes a NOP; any
        // request in flight is dropped but its flag stays set.
        if (gie_cleared) begin
            state_next.nop_due = 1'b1; // R6
        end else if (q1 && state_reg.nop_due) begin
            state_next.nop_due = 1'b0;
            state_next.ctl.nop_insert = 1'b1; // R6
        end

        take = 1'b0;
        unique case (state_reg.seq)
            RUN: begin
                if (core_event.sleep_request) begin
                    if (any_enabled) begin
                        // The sleep instruction completes, then wakes at once.
                        state_next.ctl.wake = 1'b1; // R20
                        state_next.seq = WAKE_EXEC;
                        state_next.count = WAKE_COUNT_INIT;
                    end else begin
                        state_next.seq = ASLEEP;
                        state_next.ctl.asleep = 1'b1;
                    end
                end else if (q1 && irq_line && !state_reg.nop_due) begin
                    // Counted in instruction cycles only, so a two-cycle
                    // instruction cannot stretch the latency.
                    state_next.seq = PENDING;
                    state_next.count = LATENCY_COUNT_INIT; // R7
                end
            end
            PENDING: begin
                if (!irq_line || gie_cleared) begin
                    state_next.seq = RUN; // R6
                end else if (q1) begin
                    if (state_reg.count == 2'h0) begin
                        take = 1'b1; // R7
                    end else begin
                        state_next.count = state_reg.count - 2'h1;
                    end
                end
            end
            ASLEEP: begin
                // The pin and other sources wake only through their own
                // enable, whatever global enable says.
                if (any_enabled) begin
                    state_next.ctl.wake = 1'b1; // R10 R19
                    state_next.ctl.asleep = 1'b0;
                    state_next.seq = WAKE_EXEC;
                    state_next.count = WAKE_COUNT_INIT;
                end
            end
            WAKE_EXEC: begin
                // The prefetched instruction runs before any vectoring.
                if (q1) begin
                    if (state_reg.count != 2'h0) begin
                        state_next.count = state_reg.count - 2'h1;
                    end else if (irq_line && !gie_cleared) begin
                        take = 1'b1; // R16
                    end else begin
                        state_next.seq = RUN; // R16
                    end
                end
            end
        endcase

        if (take) begin
            state_next.interrupt_control[GLOBAL_IRQ_ENABLE_BIT] = 1'b0; // R4
            state_next.ctl.vector_load = 1'b1; // R4
            state_next.ctl.push_return = 1'b1; // R4
            state_next.ctl.vector_addr = IRQ_VECTOR; // R4
            state_next.seq = RUN;
        end

        if (reset) begin
            state_next = '0;
            state_next.seq = RUN;
            state_next.option = OPTION_RESET;
            state_next.interrupt_control = INTERRUPT_CONTROL_RESET; // R2
            // The port change flag survives every reset except power-up.
            state_next.interrupt_control[PORT_CHANGE_FLAG_BIT] =
                por_reset ? 1'b0 :
                state_reg.interrupt_control[PORT_CHANGE_FLAG_BIT]; // R2
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    assign apb_resp = state_reg.apb;
    assign core_ctl = state_reg.ctl;

endmodule

// File: hdl/mcu_irq_pkg.sv
// Constants, carrier types and states for the interrupt logic block.
// Overview of operation
// R1 - Global enable passes or blocks every interrupt.
// R2 - Reset clears control register, flag bit kept.
// R3 - Flags set regardless of any enable bit.
// R4 - Accept clears global enable, pushes, vectors 0004h.
// R5 - Return from interrupt sets global enable again.
// R6 - Clearing global enable forces one skipped cycle.
// R7 - Fixed latency, independent of instruction length.
// R8 - Pin edge selectable, valid edge sets flag.
// R9 - Pin enable clear stops pin interrupt.
// R10 - Pin wakes only when enabled before sleep.
// R11 - Timer rollover sets flag, enable gates it.
// R12 - Upper port change sets flag, enable bit3.
// R13 - Change during port read may be lost.
// R14 - Comparator flag gated by two enables.
// R15 - Pin flag set Q4-Q1, sampled Q1.
// R16 - After wake run next instruction, then vector.
// R17 - Comparator wake leaves comparator flag set.
// R18 - Software clears flags before re-enabling.
// R19 - Enabled source wakes regardless of global enable.
// R20 - Pending enabled source at sleep wakes immediately.
// R21 - Request is global enable and enabled sources.
package mcu_irq_pkg;

    localparam int unsigned ADDR_WIDTH = 12;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned PC_WIDTH = 13;
    localparam int unsigned PIN_COUNT = 5;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] INTERRUPT_CONTROL_IDX = 8'h0b;
    localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_IDX = 8'h0c;
    localparam logic [7:0] OPTION_IDX = 8'h81;
    localparam logic [7:0] PERIPHERAL_IRQ_ENABLES_IDX = 8'h8c;
    localparam logic [7:0] IRQ_CORE_STATUS_IDX = 8'h90;

    // Field positions of the interrupt control register.
    localparam int unsigned GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int unsigned TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
    localparam int unsigned EXT_PIN_IRQ_ENABLE_BIT = 4;
    localparam int unsigned PORT_CHANGE_IRQ_ENABLE_BIT = 3;
    localparam int unsigned TIMER_OVERFLOW_FLAG_BIT = 2;
    localparam int unsigned EXT_PIN_IRQ_FLAG_BIT = 1;
    localparam int unsigned PORT_CHANGE_FLAG_BIT = 0;
    // Comparator flag and enable share one position in their registers.
    localparam int unsigned COMPARATOR_BIT = 6;
    localparam int unsigned EXT_EDGE_SELECT_BIT = 6;

    // Status register fields.
    localparam int unsigned STATUS_ASLEEP_BIT = 0;
    localparam int unsigned STATUS_PENDING_BIT = 1;
    localparam int unsigned STATUS_REQUEST_BIT = 2;
    localparam int unsigned STATUS_NOP_DUE_BIT = 3;

    // Reset values.
    localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    localparam logic [PC_WIDTH-1:0] IRQ_VECTOR = 13'h0004;

    // Quarter phases of one instruction cycle, one clock each.
    localparam logic [1:0] Q1_PHASE = 2'h0;
    localparam logic [1:0] Q2_PHASE = 2'h1;
    localparam logic [1:0] Q4_PHASE = 2'h3;
    localparam int unsigned CLOCK_PERIOD_NS = 20;
    localparam int unsigned Q_PHASES = 4;
    localparam int unsigned TCY_NS = CLOCK_PERIOD_NS * Q_PHASES;
    localparam int unsigned LATENCY_TCY = 3;
    localparam int unsigned LATENCY_CYCLES =
        LATENCY_TCY * TCY_NS / CLOCK_PERIOD_NS;
    localparam logic [1:0] LATENCY_COUNT_INIT = 2'(LATENCY_TCY - 1);
    localparam logic [1:0] WAKE_COUNT_INIT = 2'h1;

    typedef enum logic [1:0] {
        RUN,
        PENDING,
        ASLEEP,
        WAKE_EXEC
    } seq_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_WIDTH-1:0] paddr;
        logic [DATA_WIDTH-1:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [DATA_WIDTH-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_resp_type;

    typedef struct packed {
        logic return_from_irq;
        logic sleep_request;
        logic port_read;
        logic timer_overflow;
        logic comparator_change;
    } core_event_type;

    typedef struct packed {
        logic irq_request;
        logic vector_load;
        logic push_return;
        logic nop_insert;
        logic asleep;
        logic wake;
        logic [PC_WIDTH-1:0] vector_addr;
    } core_ctl_type;

endpackage

// File: hdl/pin_sync.sv
// Three-stage input synchroniser with agreement filter for the pins.
`timescale 1ns/1ns
module pin_sync
    import mcu_irq_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [PIN_COUNT-1:0] raw,
    output logic [PIN_COUNT-1:0] stable
);

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] stable;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;
    logic [PIN_COUNT-1:0] agree;

    always_comb begin
        state_next = state_reg;
        state_next.s1 = raw;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        // A level counts only once the second and third stage agree.
        agree = state_reg.s2 ~^ state_reg.s3;
        state_next.stable = (agree & state_reg.s3) |
            (~agree & state_reg.stable);
        if (reset) begin
            state_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    assign stable = state_reg.stable;

endmodule

// File: tb/core_model.sv
// Behavioural core: vector target, return stack depth and returns.
`timescale 1ns/1ns
module core_model
    import mcu_irq_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire mcu_irq_pkg::core_ctl_type core_ctl,
    input wire logic ret_req,
    output logic return_from_irq,
    output logic [3:0] depth,
    output logic [PC_WIDTH-1:0] pc
);
    always_ff @(posedge clock) begin
        if (reset) begin
            return_from_irq <= 1'b0;
            depth <= 4'h0;
            pc <= '0;
        end else begin
            return_from_irq <= ret_req;
            // The stack is eight deep; a deeper push is lost as in silicon.
            if (core_ctl.push_return && depth < 4'h8) begin
                depth <= depth + 4'h1;
            end else if (ret_req && depth != 4'h0) begin
                depth <= depth - 4'h1;
            end
            if (core_ctl.vector_load) begin
                pc <= core_ctl.vector_addr;
            end
        end
    end
endmodule

// File: tb/irq_properties.sv
// Concurrent checks on the ports of the interrupt logic block.
`timescale 1ns/1ns
module irq_properties
    import mcu_irq_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic por_reset,
    input wire logic ext_irq_pin,
    input wire logic [3:0] upper_nibble_port,
    input wire mcu_irq_pkg::core_event_type core_event,
    input wire mcu_irq_pkg::apb_req_type apb_req,
    input wire mcu_irq_pkg::apb_resp_type apb_resp,
    input wire mcu_irq_pkg::core_ctl_type core_ctl
);
    logic [4:0] held;
    logic [3:0] wr_age;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // A standing request must be taken; sleep and wake restart the count.
    always_ff @(posedge clock) begin
        if (reset || !core_ctl.irq_request || core_ctl.vector_load
            || core_ctl.asleep || core_ctl.wake) begin
            held <= 5'h00;
        end else if (held != 5'h1f) begin
            held <= held + 5'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_age <= 4'hf;
        end else if (apb_req.psel && apb_req.penable && apb_req.pwrite
            && apb_resp.pready) begin
            wr_age <= 4'h0;
        end else if (wr_age != 4'hf) begin
            wr_age <= wr_age + 4'h1;
        end
    end

    a_pready_follows: assert property (
        apb_req.psel && apb_req.penable && !apb_resp.pready |=>
            apb_resp.pready)
        else $error("ready missing after access phase");
    a_error_with_ready: assert property (
        apb_resp.pslverr |-> apb_resp.pready)
        else $error("error flag without ready");
    a_vector_fields: assert property (
        core_ctl.vector_load |-> core_ctl.push_return
            && core_ctl.vector_addr == IRQ_VECTOR)
        else $error("vector load without push or vector");
    a_vector_cause: assert property (
        core_ctl.vector_load |-> $past(core_ctl.irq_request))
        else $error("vector load without a request");
    a_accept_drops: assert property (
        core_ctl.vector_load |=> !core_ctl.vector_load
            ##[0:1] !core_ctl.irq_request)
        else $error("request stands after accept");
    a_latency_bound: assert property (held <= 5'h14)
        else $error("request not taken in time");
    a_nop_after_write: assert property (
        core_ctl.nop_insert |-> wr_age <= 4'h6 ##1 !core_ctl.nop_insert)
        else $error("stray or long no-operation");
    a_sleep_answer: assert property (
        core_event.sleep_request |-> ##[1:2]
            (core_ctl.asleep || core_ctl.wake))
        else $error("no sleep and no wake");
    a_wake_first: assert property (
        core_ctl.wake |-> !core_ctl.vector_load [*4])
        else $error("vector before next instruction");
    a_reset_quiet: assert property (disable iff (1'b0)
        reset |=> !core_ctl.irq_request && !core_ctl.asleep
            && !apb_resp.pready)
        else $error("outputs active after reset");
endmodule

// File: tb/testbench.sv
// Self-checking bench for the interrupt logic block.
`timescale 1ns/1ns
module testbench;
    import mcu_irq_pkg::*;
    localparam logic [7:0] CTRL = INTERRUPT_CONTROL_IDX;
    localparam logic [7:0] GLB_M = 8'(1 << GLOBAL_IRQ_ENABLE_BIT);
    localparam logic [7:0] PER_M = 8'(1 << PERIPHERAL_IRQ_ENABLE_BIT);
    localparam logic [7:0] OVF_E = 8'(1 << TIMER_OVERFLOW_IRQ_ENABLE_BIT);
    localparam logic [7:0] OVF_F = 8'(1 << TIMER_OVERFLOW_FLAG_BIT);
    localparam logic [7:0] PIN_E = 8'(1 << EXT_PIN_IRQ_ENABLE_BIT);
    localparam logic [7:0] PIN_F = 8'(1 << EXT_PIN_IRQ_FLAG_BIT);
    localparam logic [7:0] CHG_F = 8'(1 << PORT_CHANGE_FLAG_BIT);
    localparam logic [7:0] CMP_M = 8'(1 << COMPARATOR_BIT);
    logic clock = 1'b0;
    logic reset, por_reset, ext_irq_pin, ret_req, ret_pulse, rerr;
    logic [3:0] upper_nibble_port, depth;
    logic [PC_WIDTH-1:0] pc;
    logic [31:0] rdata;
    core_event_type ev, core_event;
    apb_req_type apb_req;
    apb_resp_type apb_resp;
    core_ctl_type core_ctl;
    int fail_count = 0, n_tests = 0, n_vec = 0, n_nop = 0, n_wake = 0;
    int v0, w0, k0, lat;

    always #10 clock = ~clock;
    assign core_event = core_event_type'(ev | {ret_pulse, 4'h0});
    mcu_interrupt_logic u_dut (.clock(clock), .reset(reset),
        .por_reset(por_reset), .ext_irq_pin(ext_irq_pin),
        .upper_nibble_port(upper_nibble_port), .core_event(core_event),
        .apb_req(apb_req), .apb_resp(apb_resp), .core_ctl(core_ctl));
    core_model u_core (.clock(clock), .reset(reset), .core_ctl(core_ctl),
        .ret_req(ret_req), .return_from_irq(ret_pulse), .depth(depth),
        .pc(pc));

    always @(posedge clock) begin
        if (core_ctl.vector_load === 1'b1) n_vec <= n_vec + 1;
        if (core_ctl.nop_insert === 1'b1) n_nop <= n_nop + 1;
        if (core_ctl.wake === 1'b1) n_wake <= n_wake + 1;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        @(posedge clock);
        apb_req <= '{1'b1, 1'b0, w, ADDR_WIDTH'({idx, 2'b00}),
            {24'h00_0000, d}};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (apb_resp.pready !== 1'b1 && k < 50);
        if (k >= 50) fail_count++;
        rdata = apb_resp.prdata;
        rerr = apb_resp.pslverr;
        apb_req <= '0;
    endtask
    task rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(nm, {24'h00_0000, e}, rdata);
    endtask
    // Bits: 3 sleep, 2 port read, 1 timer rollover, 0 comparator change.
    task pulse(input logic [4:0] m);
        @(posedge clock);
        ev <= core_event_type'(m);
        @(posedge clock);
        ev <= '0;
    endtask
    task ret();
        @(posedge clock);
        ret_req <= 1'b1;
        @(posedge clock);
        ret_req <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        idle(5000);
        fail_count++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        por_reset = 1'b1;
        ext_irq_pin = 1'b0;
        upper_nibble_port = 4'h0;
        ev = '0;
        apb_req = '0;
        ret_req = 1'b0;
        idle(8);
        reset <= 1'b0;
        por_reset <= 1'b0;
        rd("control", CTRL, 8'h00);
        rd("flags", PERIPHERAL_IRQ_FLAGS_IDX, 8'h00);
        rd("enables", PERIPHERAL_IRQ_ENABLES_IDX, 8'h00);
        rd("option", OPTION_IDX, OPTION_RESET);
        apb(1'b0, 8'h55, 8'h00);
        chk("unmapped error", 1, rerr);
        pulse(5'h04);
        pulse(5'h02);
        pulse(5'h01);
        idle(4);
        rd("control", CTRL, OVF_F);
        rd("flags", PERIPHERAL_IRQ_FLAGS_IDX, CMP_M);
        chk("request", 0, core_ctl.irq_request);
        $display("flag test done");
        upper_nibble_port <= 4'h9;
        idle(8);
        rd("control", CTRL, OVF_F | CHG_F);
        reset <= 1'b1;
        idle(4);
        reset <= 1'b0;
        rd("control", CTRL, CHG_F);
        pulse(5'h04);
        apb(1'b1, CTRL, 8'h00);
        rd("control", CTRL, 8'h00);
        $display("port and reset test done");
        apb(1'b1, CTRL, GLB_M | OVF_E);
        v0 = n_vec;
        pulse(5'h02);
        lat = 0;
        while (n_vec == v0 && lat < 40) begin
            @(posedge clock);
            lat++;
        end
        chk("latency", 1, 32'(lat >= 15 && lat <= 18));
        chk("vector", IRQ_VECTOR, pc);
        chk("depth", 1, depth);
        rd("control", CTRL, OVF_E | OVF_F);
        apb(1'b1, CTRL, OVF_E);
        ret();
        rd("control", CTRL, GLB_M | OVF_E);
        chk("depth", 0, depth);
        $display("timer test done");
        apb(1'b1, CTRL, GLB_M);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, OPTION_IDX, m ? 8'h00 : OPTION_RESET);
            ext_irq_pin <= m ? 1'b0 : 1'b1;
            idle(12);
            rd("control", CTRL, GLB_M | PIN_F);
            apb(1'b1, CTRL, GLB_M);
        end
        chk("vectors", v0 + 1, n_vec);
        $display("pin test done");
        apb(1'b1, CTRL, OVF_E);
        pulse(5'h02);
        v0 = n_vec;
        k0 = n_nop;
        apb(1'b1, CTRL, GLB_M | OVF_E | OVF_F);
        apb(1'b1, CTRL, OVF_E | OVF_F);
        idle(16);
        chk("vectors", v0, n_vec);
        chk("nop seen", 1, 32'(n_nop > k0));
        apb(1'b1, CTRL, GLB_M | OVF_E | OVF_F);
        idle(24);
        chk("vectors", v0 + 1, n_vec);
        apb(1'b1, CTRL, OVF_E);
        ret();
        $display("disable test done");
        apb(1'b1, PERIPHERAL_IRQ_ENABLES_IDX, CMP_M);
        apb(1'b1, CTRL, PER_M);
        apb(1'b1, OPTION_IDX, OPTION_RESET);
        w0 = n_wake;
        v0 = n_vec;
        pulse(5'h08);
        idle(2);
        chk("asleep", 1, core_ctl.asleep);
        rd("status", IRQ_CORE_STATUS_IDX, 8'h01);
        pulse(5'h01);
        idle(8);
        chk("wakes", w0 + 1, n_wake);
        chk("vectors", v0, n_vec);
        rd("flags", PERIPHERAL_IRQ_FLAGS_IDX, CMP_M);
        pulse(5'h08);
        idle(8);
        chk("wakes", w0 + 2, n_wake);
        chk("asleep", 0, core_ctl.asleep);
        apb(1'b1, PERIPHERAL_IRQ_FLAGS_IDX, 8'h00);
        apb(1'b1, CTRL, GLB_M | PIN_E);
        pulse(5'h08);
        idle(4);
        chk("asleep", 1, core_ctl.asleep);
        ext_irq_pin <= 1'b1;
        idle(24);
        chk("wakes", w0 + 3, n_wake);
        chk("vectors", v0 + 1, n_vec);
        rd("flags", PERIPHERAL_IRQ_FLAGS_IDX, 8'h00);
        $display("sleep test done");
        close_out();
    end
endmodule

bind mcu_interrupt_logic irq_properties u_props (.clock(clock),
    .reset(reset), .por_reset(por_reset), .ext_irq_pin(ext_irq_pin),
    .upper_nibble_port(upper_nibble_port), .core_event(core_event),
    .apb_req(apb_req), .apb_resp(apb_resp), .core_ctl(core_ctl));
